// file: rtl/srmc_defs.svh
// register offsets, field positions, codes and timing counts of the slave readout control
`ifndef SRMC_DEFS_SVH
`define SRMC_DEFS_SVH

// =====================================================================
// register map (byte addresses)
`define SRMC_ADDR_W 4
`define SRMC_CTRL_OFS 4'h0
`define SRMC_STATUS_OFS 4'h4
`define SRMC_ROWCNT_OFS 4'h8
`define SRMC_CTRL_RST 32'h0000_0000

// =====================================================================
// field positions
`define SRMC_CTRL_EN_BIT 0
`define SRMC_CTRL_CLR_BIT 1
`define SRMC_ST_LATE_BIT 0
`define SRMC_ST_STATE_LSB 4
`define SRMC_ST_MODE_LSB 8
`define SRMC_ST_COLB_LSB 12
`define SRMC_ST_ROWB_LSB 14
`define SRMC_ST_VSRC_BIT 16
`define SRMC_ST_CDS_BIT 17

// =====================================================================
// bus answers
`define SRMC_RESP_OKAY 2'h0
`define SRMC_RESP_SLVERR 2'h2

// =====================================================================
// pin codes
`define SRMC_VSRC_EXT 1'h1
`define SRMC_MODE_STD 2'h0
`define SRMC_MODE_ACC 2'h1
`define SRMC_MODE_XFER 2'h3
`define SRMC_BIN_1X 2'h0
`define SRMC_BIN_2X 2'h1
`define SRMC_BIN_4X 2'h2
`define SRMC_SHIFT_1X 2'h0
`define SRMC_SHIFT_2X 2'h1
`define SRMC_SHIFT_4X 2'h2

// =====================================================================
// timing: figures in 1X clock cycles, converted to system clock cycles
`define SRMC_CLK_PER_1X 1
`define SRMC_TRIG_LOW_1X 1
`define SRMC_TRIG_LOW_CYC (`SRMC_TRIG_LOW_1X * `SRMC_CLK_PER_1X)
`define SRMC_GO_WINDOW_1X 1
`define SRMC_GO_WINDOW_CYC (`SRMC_GO_WINDOW_1X * `SRMC_CLK_PER_1X)

`endif

// file: rtl/srmc_pkg.sv
// types shared by the slave readout control
package srmc_pkg;

    // =====================================================================
    // row sequencer states
    typedef enum logic [1:0] {ST_IDLE, ST_CDS, ST_WAIT_GO, ST_READOUT} srmc_state_type;

    // =====================================================================
    // decoded readout modes
    typedef enum logic [1:0] {MODE_STANDARD, MODE_ACCUM, MODE_XFER} srmc_mode_type;

endpackage

// file: rtl/srmc_bin_sel.sv
// decoder of a two-bit binning code into a resolution shift
`timescale 1ns/1ps
`include "srmc_defs.svh"

module srmc_bin_sel
(
    // code pins
    input wire logic sel_hi_i,
    input wire logic sel_lo_i,
    // decoded shift
    output logic [1:0] shift_o,
    output logic legal_o
);

    // =====================================================================
    // decode: 1X full, 2X halves, 4X quarters; unused code falls back to 1X
    always_comb
    begin
        legal_o = 1'b1;
        unique case ({sel_hi_i, sel_lo_i})
            `SRMC_BIN_1X: shift_o = `SRMC_SHIFT_1X;
            `SRMC_BIN_2X: shift_o = `SRMC_SHIFT_2X;
            `SRMC_BIN_4X: shift_o = `SRMC_SHIFT_4X;
            default:
            begin
                shift_o = `SRMC_SHIFT_1X;
                legal_o = 1'b0;
            end
        endcase
    end

endmodule

// file: rtl/srmc_top.sv
// slave readout mode control: row handshake sequencer, mode and binning selects, axi4-lite registers
//
// Local design decisions: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "srmc_defs.svh"

module srmc_top
#(
    parameter int COLS = 1024,
    parameter int CDS_CYCLES = 4,
    parameter int CNT_W = 16
)
(
    // clock, reset, enable
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic CE_I,
    // slave-mode control pins
    input wire logic ROW_CDS_TRIGGER_N_I,
    input wire logic READOUT_GO_N_I,
    input wire logic VIDEO_SOURCE_SELECT_I,
    input wire logic SAMPLING_MODE_HI_I,
    input wire logic SAMPLING_MODE_LO_I,
    input wire logic COL_BIN_SEL_HI_I,
    input wire logic COL_BIN_SEL_LO_I,
    input wire logic ROW_BIN_SEL_HI_I,
    input wire logic ROW_BIN_SEL_LO_I,
    // readout path controls
    output logic CDS_START_O,
    output logic CDS_APPLY_O,
    output logic CONV_DONE_O,
    output logic VIDEO_EXT_O,
    output logic PIXEL_VALID_O,
    output logic PIXEL_LAST_O,
    output srmc_pkg::srmc_mode_type MODE_O,
    output logic [1:0] COL_BIN_SHIFT_O,
    output logic [1:0] ROW_BIN_SHIFT_O,
    // axi4-lite write channels
    input wire logic [`SRMC_ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // axi4-lite read channels
    input wire logic [`SRMC_ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);

    import srmc_pkg::*;

    // =====================================================================
    // declarations
    srmc_state_type state_r;
    srmc_mode_type mode_r;
    srmc_mode_type mode_nxt;
    logic [1:0] col_shift_r;
    logic [1:0] row_shift_r;
    logic [1:0] col_shift_nxt;
    logic [1:0] row_shift_nxt;
    logic vid_ext_r;
    logic [31:0] ctrl_r;
    logic late_r;
    logic [CNT_W-1:0] cds_cnt_r;
    logic [CNT_W-1:0] pix_cnt_r;
    logic [CNT_W-1:0] pix_total;
    logic [CNT_W-1:0] go_cnt_r;
    logic [CNT_W-1:0] rowcnt_r;
    logic [3:0] grp_cnt_r;
    logic [3:0] grp_last;
    logic trig_n_prev_r;
    logic trig_fall;
    logic row_start;
    logic go_seen;
    logic cds_done;
    logic aw_held_r;
    logic w_held_r;
    logic [`SRMC_ADDR_W-1:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic wr_fire;
    logic wr_ctrl;
    logic wr_status;
    logic [31:0] status_word;

    // checks that an address names one of the registers
    function automatic logic addr_mapped(input logic [`SRMC_ADDR_W-1:0] a);
        addr_mapped = (a == `SRMC_CTRL_OFS) || (a == `SRMC_STATUS_OFS) || (a == `SRMC_ROWCNT_OFS);
    endfunction

    // applies byte strobes to a register word
    function automatic logic [31:0] strobe_merge(input logic [31:0] old, input logic [31:0] d,
                                                 input logic [3:0] s);
        strobe_merge = old;
        for (int b = 0; b < 4; b++)
        begin
            if (s[b])
            begin
                strobe_merge[b*8 +: 8] = d[b*8 +: 8];
            end
        end
    endfunction

    // =====================================================================
    // pin decoding: sampling mode is read as one two-bit code
    always_comb
    begin
        unique case ({SAMPLING_MODE_HI_I, SAMPLING_MODE_LO_I})
            `SRMC_MODE_ACC: mode_nxt = MODE_ACCUM;
            `SRMC_MODE_XFER: mode_nxt = MODE_XFER;
            default: mode_nxt = MODE_STANDARD;
        endcase
    end

    // column and row binning decoders
    srmc_bin_sel u_col_bin
    (
        .sel_hi_i(COL_BIN_SEL_HI_I),
        .sel_lo_i(COL_BIN_SEL_LO_I),
        .shift_o(col_shift_nxt),
        .legal_o()
    );

    srmc_bin_sel u_row_bin
    (
        .sel_hi_i(ROW_BIN_SEL_HI_I),
        .sel_lo_i(ROW_BIN_SEL_LO_I),
        .shift_o(row_shift_nxt),
        .legal_o()
    );

    // =====================================================================
    // row handshake events
    assign trig_fall = trig_n_prev_r & ~ROW_CDS_TRIGGER_N_I;
    assign row_start = (state_r == ST_IDLE) && trig_fall && ctrl_r[`SRMC_CTRL_EN_BIT];
    assign go_seen = ~READOUT_GO_N_I;
    assign cds_done = (cds_cnt_r == CNT_W'(CDS_CYCLES - 1));
    assign pix_total = CNT_W'(COLS) >> col_shift_r;
    assign grp_last = (4'h1 << row_shift_r) - 4'h1;

    // trigger history for the falling-edge detector
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            trig_n_prev_r <= 1'b1;
        else if (CE_I)
            trig_n_prev_r <= ROW_CDS_TRIGGER_N_I;
    end

    // selects are captured at the first row start of a row group; the controller keeps them still over a frame
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            mode_r <= MODE_STANDARD;
            col_shift_r <= `SRMC_SHIFT_1X;
            row_shift_r <= `SRMC_SHIFT_1X;
            vid_ext_r <= 1'b0;
        end
        else if (CE_I && row_start && grp_cnt_r == 4'h0)
        begin
            mode_r <= mode_nxt;
            col_shift_r <= col_shift_nxt;
            row_shift_r <= row_shift_nxt;
            vid_ext_r <= (VIDEO_SOURCE_SELECT_I == `SRMC_VSRC_EXT);
        end
    end

    // =====================================================================
    // row sequencer: sample, wait for go, read pixels
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            state_r <= ST_IDLE;
            cds_cnt_r <= '0;
            pix_cnt_r <= '0;
            go_cnt_r <= '0;
            grp_cnt_r <= 4'h0;
        end
        else if (CE_I)
        begin
            unique case (state_r)
                ST_IDLE:
                begin
                    cds_cnt_r <= '0;
                    if (row_start)
                        state_r <= ST_CDS;
                end
                ST_CDS:
                begin
                    cds_cnt_r <= cds_cnt_r + 1'b1;
                    go_cnt_r <= '0;
                    if (cds_done && grp_cnt_r >= grp_last)
                    begin
                        grp_cnt_r <= 4'h0;
                        state_r <= ST_WAIT_GO;
                    end
                    else if (cds_done)
                    begin
                        grp_cnt_r <= grp_cnt_r + 4'h1;
                        state_r <= ST_IDLE;
                    end
                end
                ST_WAIT_GO:
                begin
                    pix_cnt_r <= '0;
                    if (go_cnt_r != '1)
                        go_cnt_r <= go_cnt_r + 1'b1;
                    if (go_seen)
                        state_r <= ST_READOUT;
                end
                ST_READOUT:
                begin
                    pix_cnt_r <= pix_cnt_r + 1'b1;
                    if (pix_cnt_r == pix_total - 1'b1)
                        state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // sequencer outputs, all registered
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            CDS_START_O <= 1'b0;
            CDS_APPLY_O <= 1'b1;
            CONV_DONE_O <= 1'b0;
            PIXEL_VALID_O <= 1'b0;
            PIXEL_LAST_O <= 1'b0;
            VIDEO_EXT_O <= 1'b0;
            MODE_O <= MODE_STANDARD;
            COL_BIN_SHIFT_O <= `SRMC_SHIFT_1X;
            ROW_BIN_SHIFT_O <= `SRMC_SHIFT_1X;
        end
        else if (CE_I)
        begin
            CDS_START_O <= row_start;
            CDS_APPLY_O <= (mode_r != MODE_ACCUM);
            CONV_DONE_O <= (state_r == ST_CDS && cds_done && grp_cnt_r >= grp_last) ||
                           (state_r == ST_WAIT_GO && !go_seen);
            PIXEL_VALID_O <= (state_r == ST_READOUT);
            PIXEL_LAST_O <= (state_r == ST_READOUT) && (pix_cnt_r == pix_total - 1'b1);
            VIDEO_EXT_O <= vid_ext_r;
            MODE_O <= mode_r;
            COL_BIN_SHIFT_O <= col_shift_r;
            ROW_BIN_SHIFT_O <= row_shift_r;
        end
    end

    // =====================================================================
    // axi4-lite write path: address and data taken in either order
    assign wr_fire = aw_held_r && w_held_r && !S_AXI_BVALID;
    assign wr_ctrl = wr_fire && (awaddr_r == `SRMC_CTRL_OFS);
    assign wr_status = wr_fire && (awaddr_r == `SRMC_STATUS_OFS);

    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY <= 1'b1;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= `SRMC_RESP_OKAY;
        end
        else if (CE_I)
        begin
            if (S_AXI_AWVALID && S_AXI_AWREADY)
            begin
                aw_held_r <= 1'b1;
                awaddr_r <= S_AXI_AWADDR;
                S_AXI_AWREADY <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY)
            begin
                w_held_r <= 1'b1;
                wdata_r <= S_AXI_WDATA;
                wstrb_r <= S_AXI_WSTRB;
                S_AXI_WREADY <= 1'b0;
            end
            if (wr_fire)
            begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= addr_mapped(awaddr_r) ? `SRMC_RESP_OKAY : `SRMC_RESP_SLVERR;
            end
            if (S_AXI_BVALID && S_AXI_BREADY)
            begin
                S_AXI_BVALID <= 1'b0;
                S_AXI_AWREADY <= 1'b1;
                S_AXI_WREADY <= 1'b1;
            end
        end
    end

    // control register; the clear bit drops back by itself
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            ctrl_r <= `SRMC_CTRL_RST;
        else if (CE_I && wr_ctrl)
            ctrl_r <= strobe_merge(ctrl_r, wdata_r, wstrb_r);
        else if (CE_I)
            ctrl_r[`SRMC_CTRL_CLR_BIT] <= 1'b0;
    end

    // late go flag: set on a go later than the window, write one clears, set wins
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            late_r <= 1'b0;
        else if (CE_I && state_r == ST_WAIT_GO && go_seen && go_cnt_r > CNT_W'(`SRMC_GO_WINDOW_CYC))
            late_r <= 1'b1;
        else if (CE_I && wr_status && wstrb_r[0] && wdata_r[`SRMC_ST_LATE_BIT])
            late_r <= 1'b0;
    end

    // count of rows read out, cleared by the control clear bit
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            rowcnt_r <= '0;
        else if (CE_I && ctrl_r[`SRMC_CTRL_CLR_BIT])
            rowcnt_r <= '0;
        else if (CE_I && state_r == ST_READOUT && pix_cnt_r == pix_total - 1'b1)
            rowcnt_r <= rowcnt_r + 1'b1;
    end

    // =====================================================================
    // axi4-lite read path
    always_comb
    begin
        status_word = '0;
        status_word[`SRMC_ST_LATE_BIT] = late_r;
        status_word[`SRMC_ST_STATE_LSB +: 2] = state_r;
        status_word[`SRMC_ST_MODE_LSB +: 2] = mode_r;
        status_word[`SRMC_ST_COLB_LSB +: 2] = col_shift_r;
        status_word[`SRMC_ST_ROWB_LSB +: 2] = row_shift_r;
        status_word[`SRMC_ST_VSRC_BIT] = vid_ext_r;
        status_word[`SRMC_ST_CDS_BIT] = (mode_r != MODE_ACCUM);
    end

    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= '0;
            S_AXI_RRESP <= `SRMC_RESP_OKAY;
        end
        else if (CE_I)
        begin
            if (S_AXI_ARVALID && S_AXI_ARREADY)
            begin
                S_AXI_ARREADY <= 1'b0;
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP <= addr_mapped(S_AXI_ARADDR) ? `SRMC_RESP_OKAY : `SRMC_RESP_SLVERR;
                unique case (S_AXI_ARADDR)
                    `SRMC_CTRL_OFS: S_AXI_RDATA <= ctrl_r;
                    `SRMC_STATUS_OFS: S_AXI_RDATA <= status_word;
                    `SRMC_ROWCNT_OFS: S_AXI_RDATA <= 32'(rowcnt_r);
                    default: S_AXI_RDATA <= '0;
                endcase
            end
            else if (S_AXI_RVALID && S_AXI_RREADY)
            begin
                S_AXI_RVALID <= 1'b0;
                S_AXI_ARREADY <= 1'b1;
            end
        end
    end

endmodule

// file: dv/srmc_ctl_model.sv
// behavioural model of the external timing controller driving the row handshake
`timescale 1ns/1ps
module srmc_ctl_model
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // bench commands
    input wire logic row_req_i,
    input wire logic [3:0] go_dly_i,
    // sensor status and strobes
    input wire logic conv_done_i,
    output logic trig_n_o,
    output logic go_n_o
);
    int cnt_r;

    // =====================================================================
    // trigger follows each request one clock later and stays low as long as the request lasts, go answers conversion done
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            trig_n_o <= 1'b1;
            go_n_o <= 1'b1;
            cnt_r <= 0;
        end
        else
        begin
            trig_n_o <= !row_req_i;
            if (conv_done_i && go_n_o)
            begin
                if (cnt_r >= go_dly_i)
                    go_n_o <= 1'b0;
                else
                    cnt_r <= cnt_r + 1;
            end
            else if (!conv_done_i)
            begin
                go_n_o <= 1'b1; // released go line goes back high
                cnt_r <= 0;
            end
        end
    end
endmodule

// file: dv/srmc_top_properties.sv
// concurrent checks on the slave readout control ports
`timescale 1ns/1ps
module srmc_chk
#(
    parameter int COLS = 1024
)
(
    // clock and reset
    input wire logic CLK_I,
    input wire logic RST_N_I,
    // control pins
    input wire logic ROW_CDS_TRIGGER_N_I,
    input wire logic READOUT_GO_N_I,
    input wire logic VIDEO_SOURCE_SELECT_I,
    input wire logic SAMPLING_MODE_HI_I,
    input wire logic SAMPLING_MODE_LO_I,
    input wire logic COL_BIN_SEL_HI_I,
    input wire logic COL_BIN_SEL_LO_I,
    input wire logic ROW_BIN_SEL_HI_I,
    input wire logic ROW_BIN_SEL_LO_I,
    // readout controls
    input wire logic CDS_START_O,
    input wire logic CDS_APPLY_O,
    input wire logic CONV_DONE_O,
    input wire logic VIDEO_EXT_O,
    input wire logic PIXEL_VALID_O,
    input wire logic PIXEL_LAST_O,
    input wire srmc_pkg::srmc_mode_type MODE_O,
    input wire logic [1:0] COL_BIN_SHIFT_O,
    input wire logic [1:0] ROW_BIN_SHIFT_O
);
    import srmc_pkg::*;
    srmc_mode_type mode_exp;
    logic [1:0] col_exp;
    logic [1:0] row_exp;
    int pix_r;

    // =====================================================================
    // expected decodes of the select pins
    assign mode_exp = !SAMPLING_MODE_LO_I ? MODE_STANDARD : (SAMPLING_MODE_HI_I ? MODE_XFER : MODE_ACCUM);
    assign col_exp = (COL_BIN_SEL_HI_I & COL_BIN_SEL_LO_I) ? 2'h0 : {COL_BIN_SEL_HI_I, COL_BIN_SEL_LO_I};
    assign row_exp = (ROW_BIN_SEL_HI_I & ROW_BIN_SEL_LO_I) ? 2'h0 : {ROW_BIN_SEL_HI_I, ROW_BIN_SEL_LO_I};

    // pixels seen so far in the current row
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            pix_r <= 0;
        else if (PIXEL_LAST_O)
            pix_r <= 0;
        else if (PIXEL_VALID_O)
            pix_r <= pix_r + 1;
    end

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);

    // =====================================================================
    // assertions
    AST_CDS_CAUSE: assert property (CDS_START_O |-> $past(ROW_CDS_TRIGGER_N_I, 2) && !$past(ROW_CDS_TRIGGER_N_I))
        else $error("sampling start without a trigger edge");
    AST_CDS_PULSE: assert property (CDS_START_O |=> !CDS_START_O)
        else $error("sampling start longer than one cycle");
    AST_VIDEO_SRC: assert property ($changed(VIDEO_EXT_O) |-> VIDEO_EXT_O == $past(VIDEO_SOURCE_SELECT_I))
        else $error("video source latched wrong value");
    AST_CDS_APPLY: assert property (CDS_APPLY_O == (MODE_O != MODE_ACCUM))
        else $error("double sampling apply disagrees with mode");
    AST_MODE_DEC: assert property ($changed(MODE_O) |-> MODE_O == $past(mode_exp))
        else $error("readout mode decoded wrong");
    AST_COL_BIN: assert property ($changed(COL_BIN_SHIFT_O) |-> COL_BIN_SHIFT_O == $past(col_exp))
        else $error("column shift decoded wrong");
    AST_ROW_BIN: assert property ($changed(ROW_BIN_SHIFT_O) |-> ROW_BIN_SHIFT_O == $past(row_exp))
        else $error("row shift decoded wrong");
    AST_PIX_COUNT: assert property (PIXEL_LAST_O |-> PIXEL_VALID_O && pix_r + 1 == (COLS >> COL_BIN_SHIFT_O))
        else $error("row pixel count wrong");
    AST_GO_READ: assert property (CONV_DONE_O && !READOUT_GO_N_I |=> !CONV_DONE_O ##[1:2] PIXEL_VALID_O)
        else $error("go did not start readout");

    // main scenarios reached
    COV_GO: cover property (CONV_DONE_O && !READOUT_GO_N_I);
    COV_LAST: cover property (PIXEL_LAST_O);
    COV_ACC: cover property (MODE_O == MODE_ACCUM && PIXEL_VALID_O);
endmodule

bind srmc_top srmc_chk #(.COLS(COLS)) i_chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
    .ROW_CDS_TRIGGER_N_I(ROW_CDS_TRIGGER_N_I), .READOUT_GO_N_I(READOUT_GO_N_I),
    .VIDEO_SOURCE_SELECT_I(VIDEO_SOURCE_SELECT_I), .SAMPLING_MODE_HI_I(SAMPLING_MODE_HI_I),
    .SAMPLING_MODE_LO_I(SAMPLING_MODE_LO_I), .COL_BIN_SEL_HI_I(COL_BIN_SEL_HI_I), .COL_BIN_SEL_LO_I(COL_BIN_SEL_LO_I),
    .ROW_BIN_SEL_HI_I(ROW_BIN_SEL_HI_I), .ROW_BIN_SEL_LO_I(ROW_BIN_SEL_LO_I), .CDS_START_O(CDS_START_O),
    .CDS_APPLY_O(CDS_APPLY_O), .CONV_DONE_O(CONV_DONE_O), .VIDEO_EXT_O(VIDEO_EXT_O), .PIXEL_VALID_O(PIXEL_VALID_O),
    .PIXEL_LAST_O(PIXEL_LAST_O), .MODE_O(MODE_O), .COL_BIN_SHIFT_O(COL_BIN_SHIFT_O), .ROW_BIN_SHIFT_O(ROW_BIN_SHIFT_O));

// file: dv/tb_slave_readout_mode_control.sv
// self-checking bench of the slave readout control with a timing controller model
`timescale 1ns/1ps
`include "srmc_defs.svh"
module tb_slave_readout_mode_control;
    import srmc_pkg::*;
    localparam int COLS = 8;
    localparam int CDS = 4;
    localparam int LIMIT = 20000;
    logic clk = 0;
    logic rst_n = 0;
    logic req = 0, ce = 1;
    logic [3:0] dly = 0;
    logic vsel = 0, mhi = 0, mlo = 0, chi = 0, clo = 0, rhi = 0, rlo = 0;
    logic trig_n, go_n, cds_start, cds_apply, conv_done, vext, pvalid, plast;
    srmc_mode_type mode;
    logic [1:0] csh, rsh, bresp, rresp, r;
    logic [3:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    int error_cnt = 0, checks_done = 0, cyc = 0, pix = 0, cds_n = 0, cs, rs, vs;
    int exp_q[$];

    // =====================================================================
    // clock, design, controller model
    always #12.5 clk = ~clk;

    srmc_top #(.COLS(COLS), .CDS_CYCLES(CDS)) i_dut (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce),
        .ROW_CDS_TRIGGER_N_I(trig_n), .READOUT_GO_N_I(go_n), .VIDEO_SOURCE_SELECT_I(vsel),
        .SAMPLING_MODE_HI_I(mhi), .SAMPLING_MODE_LO_I(mlo), .COL_BIN_SEL_HI_I(chi), .COL_BIN_SEL_LO_I(clo),
        .ROW_BIN_SEL_HI_I(rhi), .ROW_BIN_SEL_LO_I(rlo), .CDS_START_O(cds_start), .CDS_APPLY_O(cds_apply),
        .CONV_DONE_O(conv_done), .VIDEO_EXT_O(vext), .PIXEL_VALID_O(pvalid), .PIXEL_LAST_O(plast), .MODE_O(mode),
        .COL_BIN_SHIFT_O(csh), .ROW_BIN_SHIFT_O(rsh), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

    srmc_ctl_model i_ctl (.clk_i(clk), .rst_n_i(rst_n), .row_req_i(req), .go_dly_i(dly),
        .conv_done_i(conv_done), .trig_n_o(trig_n), .go_n_o(go_n));

    // =====================================================================
    // pixel and start counters, hang guard
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (pvalid === 1'b1)
            pix <= pix + 1;
        if (cds_start === 1'b1)
            cds_n <= cds_n + 1;
        if (cyc == LIMIT)
        begin
            error_cnt++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            error_cnt++;
            $display("mismatch %s exp %0h got %0h", nm, e, g);
        end
    endtask

    // bus write: address and data offered together, each released when taken
    task automatic axw(input logic [3:0] a, input logic [31:0] dt, output logic [1:0] rp);
        logic aw_t, w_t;
        aw_t = 0;
        w_t = 0;
        awaddr <= a;
        wdata <= dt;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do
        begin
            @(posedge clk);
            if (awvalid && awready)
            begin
                aw_t = 1;
                awvalid <= 0;
            end
            if (wvalid && wready)
            begin
                w_t = 1;
                wvalid <= 0;
            end
        end while (!(aw_t && w_t));
        do @(posedge clk); while (bvalid !== 1'b1);
        rp = bresp;
    endtask

    task automatic axr(input logic [3:0] a, output logic [31:0] dt, output logic [1:0] rp);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 0;
        while (rvalid !== 1'b1) @(posedge clk);
        dt = rdata;
        rp = rresp;
    endtask

    // one row group of n triggers, go answered after dl cycles
    task automatic grp(input int n, input logic [3:0] dl);
        dly <= dl;
        pix <= 0;
        for (int k = 0; k < n; k++)
        begin
            @(posedge clk) req <= 1;
            @(posedge clk) req <= 0;
            if (k < n - 1)
            begin
                repeat (CDS + 4) @(posedge clk);
                chk("conv_done", 32'h0, conv_done);
            end
        end
        while (plast !== 1'b1) @(posedge clk);
        @(posedge clk);
    endtask

    // =====================================================================
    // main sequence
    initial
    begin
        void'($urandom(73));
        repeat (2) @(posedge clk);
        rst_n <= 1;
        axr(4'h0, d, r);
        chk("ctrl", 32'h0, d);
        axr(4'h4, d, r);
        chk("status", 32'h0002_0000, d);
        axr(4'hC, d, r);
        chk("rd resp", 32'h2, 32'(r));
        chk("rd data", 32'h0, d);
        axw(4'hC, 32'h1, r);
        chk("wr resp", 32'h2, 32'(r));
        @(posedge clk) req <= 1;
        @(posedge clk) req <= 0;
        repeat (10) @(posedge clk);
        chk("disabled start", 32'h0, cds_n);
        $display("test refused done");
        axw(4'h0, 32'h1, r);
        // a trigger pulse while the clock enable is low must leave no trace
        ce <= 0;
        @(posedge clk) req <= 1;
        @(posedge clk) req <= 0;
        repeat (4) @(posedge clk);
        ce <= 1;
        chk("frozen start", 32'h0, cds_n);
        for (int i = 0; i < 4; i++)
        begin
            cs = (i == 3) ? 0 : i;
            rs = (i == 0) ? 0 : 3 - i;
            vs = $urandom % 2;
            @(posedge clk);
            {mhi, mlo} <= i[1:0];
            {chi, clo} <= i[1:0];
            {rhi, rlo} <= 2'(3 - i);
            vsel <= vs[0];
            repeat (3) @(posedge clk);
            exp_q.push_back(COLS >> cs);
            grp(1 << rs, 4'h0);
            chk("pixels", exp_q.pop_front(), pix);
            chk("col shift", cs, csh);
            chk("row shift", rs, rsh);
            chk("video", vs, vext);
            chk("mode", i[0] ? (i[1] ? MODE_XFER : MODE_ACCUM) : MODE_STANDARD, mode);
            chk("cds apply", i != 1, cds_apply);
        end
        axr(4'h4, d, r);
        chk("late prompt", 32'h0, d[0]);
        $display("test modes done");
        grp(1, 4'h3);
        axr(4'h4, d, r);
        chk("late set", 32'h1, d[0]);
        axw(4'h4, 32'h1, r);
        axr(4'h4, d, r);
        chk("late clear", 32'h0, d[0]);
        axr(4'h8, d, r);
        chk("rowcnt", 32'h5, d);
        axw(4'h0, 32'h3, r);
        axr(4'h8, d, r);
        chk("rowcnt clear", 32'h0, d);
        $display("test late go done");
        summarize();
    end
endmodule
